// file: vilc_cfg.svh
// Address map, field positions, vectors and reset values of the interrupt level controller.
`ifndef VILC_CFG_SVH
`define VILC_CFG_SVH
// Register addresses in the register file.
`define VILC_ADDR_REQ 8'hdc
`define VILC_ADDR_MASK 8'hdd
`define VILC_ADDR_MODE 8'hde
`define VILC_ADDR_PRIO 8'hff
// Mode register fields and reset values.
`define VILC_MODE_GIE 0
`define VILC_MODE_FAST 1
`define VILC_MODE_FLVL_LO 2
`define VILC_MODE_FLVL_HI 4
`define VILC_MODE_RST 5'h00
`define VILC_MASK_RST 8'h00
`define VILC_PRIO_RST 8'h00
`define VILC_REQ_RST 8'h00
// Priority register fields.
`define VILC_PRIO_A 0
`define VILC_PRIO_B 2
`define VILC_PRIO_BSUB 3
`define VILC_PRIO_C 5
`define VILC_PRIO_CSUB 6
`define VILC_PRIO_GRP_LO 1
`define VILC_PRIO_GRP_MID 4
`define VILC_PRIO_GRP_HI 7
// Program entry after reset.
`define VILC_RESET_VEC 16'h0100
// Source count and vectors, sources numbered by rising vector within a level.
`define VILC_NUM_SRC 17
`define VILC_VEC_T0_MATCH 8'he0
`define VILC_VEC_T0_OVF 8'he2
`define VILC_VEC_T2_MATCH 8'he4
`define VILC_VEC_T1_MATCH 8'he6
`define VILC_VEC_SER1 8'he8
`define VILC_VEC_SER0 8'hea
`define VILC_VEC_WATCH 8'hf2
`define VILC_VEC_P1_BASE 8'hd0
`define VILC_VEC_CE 8'hc0
`define VILC_VEC_IF 8'hc2
`endif

// file: vilc_core_model.sv
// Core-side model that takes offered interrupts and acknowledges them.
`timescale 1ns/10ps
`default_nettype none
module vilc_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic int_req,
    input wire logic [7:0] int_vec,
    input wire logic [2:0] int_level,
    input wire logic accept,
    input wire logic [2:0] delay,
    output logic int_ack,
    output logic [10:0] got,
    output logic unstable
);
    logic [2:0] wait_q;
    logic held_q;
    logic [10:0] last_q;
    // ==========
    // Acknowledge
    // Waits the chosen number of cycles, then grants with a one-cycle pulse and keeps the vector.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q <= 3'h0;
            int_ack <= 1'b0;
            got <= 11'h000;
            unstable <= 1'b0;
            held_q <= 1'b0;
            last_q <= 11'h000;
        end
        else
        begin
            int_ack <= 1'b0;
            held_q <= int_req;
            last_q <= {int_level, int_vec};
            if (int_req && held_q && ({int_level, int_vec} !== last_q))
                unstable <= 1'b1;
            if (int_req && accept && !int_ack)
            begin
                if (wait_q == delay)
                begin
                    // The grant records the offered level and vector in got.
                    int_ack <= 1'b1;
                    got <= {int_level, int_vec};
                    wait_q <= 3'h0;
                end
                else
                    wait_q <= wait_q + 3'h1;
            end
            else if (!int_req)
                wait_q <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: vilc_ctrl.sv
// Vectored interrupt level controller: masking, level priority and request offer to the core.
`timescale 1ns/10ps
`default_nettype none
`include "vilc_cfg.svh"

// How it works
// - Reset entry vector is fixed 0100H.
// - Vectors are 8-bit offsets, low 256 bytes.
// - Levels 0-3 carry timers, serials, watch timer.
// - Levels 4-7 carry port pins, CE, IF.
// - Priority zero in a level wins.
// - Same level: lowest vector address granted.
// - Enable sets, disable clears mode bit 0.
// - Enabled: serve pending by programmed priorities.
// - Global disable always takes effect.
// - Cleared mask bit blocks its level.
// - Groups A, B, C order the levels.
// - Request register is read-only per-level pending.
// - Mode register holds fast interrupt control.
// - Source needs own, level, global enable.
// - Mask bit n enables level n.
// - Request bits reset zero, update while disabled.
// - Reset clears mode bits 0 and 1.
// - Grant disables all other interrupts.
module vilc_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic global_on_instruction,
    input wire logic global_off_instruction,
    input wire logic [`VILC_NUM_SRC-1:0] src_req,
    input wire logic [`VILC_NUM_SRC-1:0] src_en,
    output logic int_req,
    output logic [7:0] int_vec,
    output logic [2:0] int_level,
    input wire logic int_ack,
    output logic fast_en,
    output logic [2:0] fast_level,
    output logic [15:0] reset_vec
);

    // ========================================
    // Source tables
    // Vector offset of each source; index order equals vector order inside a level.
    function automatic vilc_pkg::vilc_vec_t src_vec(input int idx);
        vilc_pkg::vilc_vec_t v;
        v = `VILC_VEC_IF;
        case (idx)
            0: v = `VILC_VEC_T0_MATCH;
            1: v = `VILC_VEC_T0_OVF;
            2: v = `VILC_VEC_T2_MATCH;
            3: v = `VILC_VEC_T1_MATCH;
            4: v = `VILC_VEC_SER1;
            5: v = `VILC_VEC_SER0;
            6: v = `VILC_VEC_WATCH;
            15: v = `VILC_VEC_CE;
            16: v = `VILC_VEC_IF;
            default: v = `VILC_VEC_P1_BASE + 8'((idx - 7) * 2);
        endcase
        return v;
    endfunction

    // Level of each source.
    function automatic vilc_pkg::vilc_level_t src_lvl(input int idx);
        vilc_pkg::vilc_level_t l;
        if (idx < 2)
            l = 3'h0;
        else if (idx < 4)
            l = 3'h1;
        else if (idx < 6)
            l = 3'h2;
        else if (idx < 7)
            l = 3'h3;
        else if (idx < 11)
            l = 3'h4;
        else if (idx < 15)
            l = 3'h5;
        else if (idx < 16)
            l = 3'h6;
        else
            l = 3'h7;
        return l;
    endfunction

    // Level order from the priority register, highest first in the top three bits.
    function automatic logic [23:0] level_rank(input logic [7:0] prio);
        logic [5:0] a;
        logic [8:0] b;
        logic [8:0] c;
        logic [23:0] r;
        a = prio[`VILC_PRIO_A] ? {3'h1, 3'h0} : {3'h0, 3'h1};
        b = prio[`VILC_PRIO_BSUB] ? {3'h4, 3'h3, 3'h2} : {3'h3, 3'h4, 3'h2};
        if (!prio[`VILC_PRIO_B])
            b = {3'h2, b[8:3]};
        c = prio[`VILC_PRIO_CSUB] ? {3'h7, 3'h6, 3'h5} : {3'h6, 3'h7, 3'h5};
        if (!prio[`VILC_PRIO_C])
            c = {3'h5, c[8:3]};
        case ({prio[`VILC_PRIO_GRP_HI], prio[`VILC_PRIO_GRP_MID], prio[`VILC_PRIO_GRP_LO]})
            3'h1: r = {b, c, a};
            3'h2: r = {a, b, c};
            3'h3: r = {b, a, c};
            3'h4: r = {c, a, b};
            3'h5: r = {c, b, a};
            3'h6: r = {a, c, b};
            default: r = {a, b, c};
        endcase
        return r;
    endfunction

    // ========================================
    // Registers
    logic [7:0] mask_q, mask_d;
    logic [7:0] prio_q, prio_d;
    logic [4:0] mode_q, mode_d;
    logic [7:0] lreq_q, lreq_d;
    logic [7:0] rdata_q, rdata_d;
    logic [15:0] rvec_q;
    vilc_pkg::vilc_state_t st_q, st_d;
    logic [7:0] vec_q, vec_d;
    logic [2:0] lvl_q, lvl_d;
    logic [`VILC_NUM_SRC-1:0] elig;
    logic [7:0] lvl_elig;
    logic [23:0] rank;
    logic found;
    vilc_pkg::vilc_level_t sel_l;
    vilc_pkg::vilc_vec_t sel_v;

    // Eligible sources and level request summary.
    always_comb
    begin
        lvl_elig = 8'h00;
        lreq_d = 8'h00;
        for (int i = 0; i < `VILC_NUM_SRC; i++)
        begin
            elig[i] = src_req[i] & src_en[i] & mask_q[src_lvl(i)];
            lvl_elig[src_lvl(i)] |= elig[i];
            lreq_d[src_lvl(i)] |= src_req[i] & src_en[i];
        end
    end

    // Winner: best ranked level, then lowest vector in it.
    always_comb
    begin
        rank = level_rank(prio_q);
        found = 1'b0;
        sel_l = 3'h0;
        sel_v = 8'h00;
        for (int k = 0; k < 8; k++)
        begin
            if (!found && lvl_elig[rank[(21 - 3 * k) +: 3]])
            begin
                found = 1'b1;
                sel_l = rank[(21 - 3 * k) +: 3];
            end
        end
        for (int i = `VILC_NUM_SRC - 1; i >= 0; i--)
        begin
            if (elig[i] && src_lvl(i) == sel_l)
                sel_v = src_vec(i);
        end
    end

    // Register writes, enable and disable instructions, grant effects.
    always_comb
    begin
        mask_d = mask_q;
        prio_d = prio_q;
        mode_d = mode_q;
        if (reg_wr && reg_addr == `VILC_ADDR_MASK)
            mask_d = reg_wdata;
        else if (reg_wr && reg_addr == `VILC_ADDR_PRIO)
            prio_d = reg_wdata;
        else if (reg_wr && reg_addr == `VILC_ADDR_MODE)
            mode_d = reg_wdata[4:0];
        if (global_on_instruction)
            mode_d[`VILC_MODE_GIE] = 1'b1;
        if (st_q == vilc_pkg::VILC_OFFER && int_ack)
            mode_d[`VILC_MODE_GIE] = 1'b0;
        if (global_off_instruction)
            mode_d[`VILC_MODE_GIE] = 1'b0;
        rdata_d = 8'h00;
        if (reg_rd && reg_addr == `VILC_ADDR_MASK)
            rdata_d = mask_q;
        else if (reg_rd && reg_addr == `VILC_ADDR_PRIO)
            rdata_d = prio_q;
        else if (reg_rd && reg_addr == `VILC_ADDR_MODE)
            rdata_d = {3'h0, mode_q};
        else if (reg_rd && reg_addr == `VILC_ADDR_REQ)
            rdata_d = lreq_q;
    end

    // Offer to the core, held stable until acknowledge or global disable.
    always_comb
    begin
        st_d = st_q;
        vec_d = vec_q;
        lvl_d = lvl_q;
        case (st_q)
            vilc_pkg::VILC_IDLE:
            begin
                if (found && mode_q[`VILC_MODE_GIE] && !global_off_instruction)
                begin
                    st_d = vilc_pkg::VILC_OFFER;
                    vec_d = sel_v;
                    lvl_d = sel_l;
                end
            end
            default:
            begin
                if (int_ack || global_off_instruction)
                    st_d = vilc_pkg::VILC_IDLE;
            end
        endcase
    end

    // State registers; the reset entry vector is a constant register.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mask_q <= `VILC_MASK_RST;
            prio_q <= `VILC_PRIO_RST;
            mode_q <= `VILC_MODE_RST;
            lreq_q <= `VILC_REQ_RST;
            rdata_q <= 8'h00;
            rvec_q <= `VILC_RESET_VEC;
            st_q <= vilc_pkg::VILC_IDLE;
            vec_q <= 8'h00;
            lvl_q <= 3'h0;
        end
        else
        begin
            mask_q <= mask_d;
            prio_q <= prio_d;
            mode_q <= mode_d;
            lreq_q <= lreq_d;
            rdata_q <= rdata_d;
            rvec_q <= rvec_q;
            st_q <= st_d;
            vec_q <= vec_d;
            lvl_q <= lvl_d;
        end
    end

    // Outputs.
    assign reg_rdata = rdata_q;
    assign int_req = (st_q == vilc_pkg::VILC_OFFER);
    assign int_vec = vec_q;
    assign int_level = lvl_q;
    assign fast_en = mode_q[`VILC_MODE_FAST];
    assign fast_level = mode_q[`VILC_MODE_FLVL_HI:`VILC_MODE_FLVL_LO];
    assign reset_vec = rvec_q;

    // ========================================
    // Checks
    reset_entry_a: assert property (@(posedge clk) disable iff (!nrst) reset_vec == 16'h0100)
        else $error("Reset entry vector changed.");
    gie_set_a: assert property (@(posedge clk) disable iff (!nrst)
        global_on_instruction && !global_off_instruction && !int_ack |=> mode_q[0])
        else $error("Enable instruction did not set global enable.");
    gie_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        global_off_instruction |=> !mode_q[0] && !int_req)
        else $error("Disable instruction did not take effect.");
    offer_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(int_req) |-> $past(mask_q[lvl_d]) && $past(mode_q[0]))
        else $error("Request offered for masked level or while disabled.");
    offer_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        int_req && !int_ack && !global_off_instruction |=> int_req && $stable(int_vec) && $stable(int_level))
        else $error("Offered request changed before acknowledge.");
    grant_off_a: assert property (@(posedge clk) disable iff (!nrst)
        int_req && int_ack |=> !mode_q[0] ##1 !int_req)
        else $error("Grant did not disable other interrupts.");
    level_req_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> lreq_q[7:6] == $past(src_req[16:15] & src_en[16:15])
        && lreq_q[3] == $past(src_req[6] & src_en[6])
        && lreq_q[0] == $past(|(src_req[1:0] & src_en[1:0])))
        else $error("Level request register lags its sources.");
    vec_level_a: assert property (@(posedge clk) disable iff (!nrst)
        int_req && int_level == 3'h3 |-> int_vec == 8'hf2)
        else $error("Watch timer vector wrong.");
    pin_vec_a: assert property (@(posedge clk) disable iff (!nrst)
        int_req && int_level == 3'h4 |-> int_vec[7:3] == 5'h1a && !int_vec[0])
        else $error("Port pin vector outside its level range.");
    low_vec_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(int_req) && int_level == 3'h0 && $past(elig[0]) |-> int_vec == 8'he0)
        else $error("Lower vector in level lost contention.");

endmodule
`default_nettype wire

// file: vilc_ctrl_bench.sv
// Self-checking testbench of the interrupt level controller.
`timescale 1ns/10ps
`default_nettype none
`include "vilc_cfg.svh"
module vilc_ctrl_bench;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, on_i = 1'b0, off_i = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, int_vec;
    logic [16:0] src_req = 17'h00000, src_en = 17'h00000;
    logic int_req, int_ack, fast_en, accept = 1'b1, unstable;
    logic [2:0] int_level, fast_level, delay = 3'h0;
    logic [15:0] reset_vec;
    logic [10:0] got;
    int fails = 0, n_compared = 0, best, k;
    logic [7:0] m, p, lr;
    vilc_ctrl DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_on_instruction(on_i),
        .global_off_instruction(off_i), .src_req(src_req), .src_en(src_en), .int_req(int_req),
        .int_vec(int_vec), .int_level(int_level), .int_ack(int_ack), .fast_en(fast_en),
        .fast_level(fast_level), .reset_vec(reset_vec));
    vilc_core_model u_core (.clk(clk), .nrst(nrst), .int_req(int_req), .int_vec(int_vec), .int_level(int_level),
        .accept(accept), .delay(delay), .int_ack(int_ack), .got(got), .unstable(unstable));
    // ==========
    // Helpers
    // Clock and watchdog.
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #100us;
        fails++;
        final_report();
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk(reg_rdata, e);
        tick();
    endtask
    task automatic pulse(input logic off);
        if (off)
            off_i = 1'b1;
        else
            on_i = 1'b1;
        tick();
        off_i = 1'b0;
        on_i = 1'b0;
        tick();
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Level, vector and rank of a level under a priority setting.
    function automatic int lv(int i);
        return i < 6 ? i / 2 : i == 6 ? 3 : i < 11 ? 4 : i < 15 ? 5 : i - 9;
    endfunction
    function automatic logic [7:0] vec(int i);
        return i < 6 ? 8'(8'he0 + 2 * i) : i == 6 ? 8'hf2 : i < 15 ? 8'(8'hd0 + 2 * (i - 7)) : 8'(8'hc0 + 2 * (i - 15));
    endfunction
    function automatic int rank(logic [7:0] q, int l);
        int t, s;
        case ({q[7], q[4], q[1]})
            3'h1: t = 12'h201;
            3'h3: t = 12'h102;
            3'h4: t = 12'h120;
            3'h5: t = 12'h210;
            3'h6: t = 12'h021;
            default: t = 12'h012;
        endcase
        if (l < 2)
            s = (l == 1) ^ q[0];
        else if (l < 5)
            s = l == 2 ? (q[2] ? 2 : 0) : (q[2] ? 0 : 1) + ((l == 4) ^ q[3]);
        else
            s = l == 5 ? (q[5] ? 2 : 0) : (q[5] ? 0 : 1) + ((l == 7) ^ q[6]);
        return ((t >> (4 * (l < 2 ? 2 : l < 5 ? 1 : 0))) & 'hf) * 4 + s;
    endfunction
    // ==========
    // Tests
    initial
    begin
        void'($urandom(32'h1bb58349));
        repeat (20) tick();
        nrst = 1'b1;
        tick();
        chk(reset_vec, 16'h0100);
        rd(`VILC_ADDR_REQ, 8'h00);
        rd(`VILC_ADDR_MODE, 8'h00);
        $display("test reset done");
        wr(`VILC_ADDR_MODE, 8'hfe);
        rd(`VILC_ADDR_MODE, 8'h1e);
        chk({fast_en, fast_level}, 4'hf);
        pulse(1'b0);
        rd(`VILC_ADDR_MODE, 8'h1f);
        pulse(1'b1);
        rd(`VILC_ADDR_MODE, 8'h1e);
        wr(`VILC_ADDR_REQ, 8'hff);
        rd(`VILC_ADDR_REQ, 8'h00);
        rd(8'h10, 8'h00);
        $display("test registers done");
        for (int it = 0; it < 60; it++)
        begin
            src_req = 17'($urandom);
            src_en = 17'($urandom);
            m = 8'($urandom);
            p = 8'($urandom);
            if (it < 17)
            begin
                src_req = 17'h00001 << it;
                src_en = src_req;
                m = 8'hff;
            end
            accept = (it % 4) != 3;
            delay = 3'($urandom_range(7));
            lr = 8'h00;
            best = -1;
            for (int i = 0; i < 17; i++)
            begin
                if (src_req[i] && src_en[i])
                    lr[lv(i)] = 1'b1;
                if (src_req[i] && src_en[i] && m[lv(i)] && (best < 0 || rank(p, lv(i)) < rank(p, lv(best))))
                    best = i;
            end
            wr(`VILC_ADDR_MASK, m);
            wr(`VILC_ADDR_PRIO, p);
            rd(`VILC_ADDR_MASK, m);
            rd(`VILC_ADDR_PRIO, p);
            rd(`VILC_ADDR_REQ, lr);
            pulse(1'b0);
            for (k = 0; k < 4 && int_req !== 1'b1; k++)
                tick();
            if (best < 0)
                chk(int_req, 1'b0);
            else
            begin
                chk({int_level, int_vec}, {3'(lv(best)), vec(best)});
                for (k = 0; k < 12 && int_req === 1'b1 && accept; k++)
                    tick();
                if (accept)
                    chk(got, {3'(lv(best)), vec(best)});
            end
            if (best < 0 || !accept)
            begin
                pulse(1'b1);
                chk(int_req, 1'b0);
            end
            rd(`VILC_ADDR_MODE, 8'h1e);
        end
        chk(unstable, 1'b0);
        $display("test offers done");
        final_report();
    end
endmodule
`default_nettype wire

// file: vilc_pkg.sv
// Types shared by the interrupt level controller.
package vilc_pkg;
    typedef enum logic {VILC_IDLE = 1'b0, VILC_OFFER = 1'b1} vilc_state_t;
    typedef logic [2:0] vilc_level_t;
    typedef logic [7:0] vilc_vec_t;
endpackage
